// *** core/fspc_pkg.sv ***
// Purpose: Constants for the flash security and program store control block
// Assumes: 16-bit program address, 8-bit data, SFR-style register port
// Notes: One package shared by the control core and the lock evaluator
package fspc_pkg;
   // ***********************************************************************
   // Register offsets and resets
   // ***********************************************************************
   localparam logic [7:0] FSPC_PGMCTL_OFS = 8'h8f;
   localparam logic [7:0] FSPC_FCTL_OFS = 8'hb6;
   localparam logic [7:0] FSPC_LIMIT_OFS = 8'hb7;
   localparam logic [7:0] FSPC_PGMCTL_RST = 8'h00;
   localparam logic [7:0] FSPC_FCTL_RST = 8'h80;
   localparam logic [7:0] FSPC_LIMIT_RST = 8'h00;
   // ***********************************************************************
   // Field positions
   // ***********************************************************************
   localparam int FSPC_WR_EN_BIT = 0;
   localparam int FSPC_ER_EN_BIT = 1;
   localparam int FSPC_SCR_SEL_BIT = 2;
   localparam int FSPC_FLSW_EN_BIT = 0;
   localparam int FSPC_RDALW_BIT = 6;
   localparam int FSPC_ONESHOT_BIT = 7;
   localparam logic [7:0] FSPC_PGMCTL_MASK = 8'h07;
   localparam logic [7:0] FSPC_FCTL_MASK = 8'hc1;
   // ***********************************************************************
   // Flash map
   // ***********************************************************************
   localparam logic [15:0] FSPC_WELOCK_ADDR = 16'hfdfe;
   localparam logic [15:0] FSPC_RDLOCK_ADDR = 16'hfdff;
   localparam logic [15:0] FSPC_LOCK_PAGE_BASE = 16'hfc00;
   localparam int FSPC_BLOCK_SHIFT = 13;
   localparam int FSPC_PAGE_SHIFT = 9;
   localparam logic [7:0] FSPC_ERASED_BYTE = 8'hff;
   localparam logic [7:0] FSPC_ZERO_BYTE = 8'h00;
   localparam logic [7:0] FSPC_UNDEF_BYTE = 8'h00;
   // ***********************************************************************
   // Flash operation codes and core states
   // ***********************************************************************
   typedef enum logic [1:0] {
      FSPC_OP_NONE = 2'b00,
      FSPC_OP_WRITE = 2'b01,
      FSPC_OP_PAGE_ERASE = 2'b10,
      FSPC_OP_MASS_ERASE = 2'b11
   } fspc_op_t;
   typedef enum logic [1:0] {
      FSPC_ST_IDLE = 2'b00,
      FSPC_ST_BUSY = 2'b01,
      FSPC_ST_LOAD = 2'b10
   } fspc_state_t;
endpackage : fspc_pkg

// *** core/fspc_lock_eval.sv ***
// Purpose: Decide JTAG read and write/erase permission from the lock bytes
// Assumes: Lock bytes already captured from flash; addresses are 16-bit
// Notes: Registered outputs, one cycle behind the request address
`timescale 1ns/1ps
module fspc_lock_eval
   import fspc_pkg::*;
#(
   parameter int ADDR_W = 16
) (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic [7:0] rd_lock,
   input wire logic [7:0] we_lock,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic scratch,
   output logic rd_ok_r,
   output logic we_ok_r
);
   initial begin
      if (ADDR_W != 16) $error("fspc_lock_eval needs a 16-bit address");
   end
   logic [2:0] blk;
   logic is_lock;
   assign blk = addr[ADDR_W-1:FSPC_BLOCK_SHIFT];
   assign is_lock = (addr == FSPC_WELOCK_ADDR) || (addr == FSPC_RDLOCK_ADDR);
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rd_ok_r <= 1'b0;
         we_ok_r <= 1'b0;
      end else if (scratch) begin
         rd_ok_r <= |rd_lock;
         we_ok_r <= |we_lock;
      end else begin
         rd_ok_r <= is_lock | rd_lock[blk];
         we_ok_r <= is_lock | we_lock[blk];
      end
   end
endmodule : fspc_lock_eval

// *** core/fspc_core.sv ***
// Purpose: Flash security and program store control
// Assumes: Flash array outside; it accepts one op per flash_req pulse and raises flash_done
// Notes: Lock bytes are reloaded from the array after every reset and every change
`timescale 1ns/1ps
module fspc_core
   import fspc_pkg::*;
#(
   parameter int ADDR_W = 16
) (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata_r,
   input wire logic sw_wr,
   input wire logic sw_rd,
   input wire logic [ADDR_W-1:0] sw_addr,
   input wire logic [7:0] sw_wdata,
   input wire logic [ADDR_W-1:0] sw_pc,
   output logic [7:0] sw_rdata_r,
   output logic sw_rvalid_r,
   input wire logic jt_rd,
   input wire logic jt_wr,
   input wire logic jt_erase,
   input wire logic [ADDR_W-1:0] jt_addr,
   input wire logic [7:0] jt_wdata,
   output logic [7:0] jt_rdata_r,
   output logic jt_rvalid_r,
   output logic jt_refused_r,
   output logic debug_ok_r,
   output logic flash_req_r,
   output fspc_op_t flash_op_r,
   output logic [ADDR_W-1:0] flash_addr_r,
   output logic [7:0] flash_wdata_r,
   output logic flash_scratch_r,
   output logic flash_rd_r,
   input wire logic flash_done,
   input wire logic [7:0] flash_rdata,
   output logic oneshot_en_r,
   output logic read_always_r,
   output logic busy_r
);
   initial begin
      if (ADDR_W != 16) $error("fspc_core needs a 16-bit address");
   end
   // ***********************************************************************
   // Registers
   // ***********************************************************************
   logic [7:0] pgm_ctl_r;
   logic [7:0] fctl_r;
   logic [7:0] limit_r;
   logic limit_done_r;
   logic [7:0] rd_lock_r;
   logic [7:0] we_lock_r;
   logic jt_pend_r;
   logic [2:0] jt_req_r;
   logic rd_src_r;
   logic [1:0] load_cnt_r;
   fspc_state_t state_r;
   logic rd_ok;
   logic we_ok;
   logic [ADDR_W-1:0] limit_addr;
   logic upper_code;
   logic below;
   logic sw_wr_ok;
   logic sw_er;
   logic in_lock_page;
   logic is_lock_adr;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         pgm_ctl_r <= FSPC_PGMCTL_RST;
         fctl_r <= FSPC_FCTL_RST;
      end else if (sfr_wr) begin
         if (sfr_addr == FSPC_PGMCTL_OFS) begin
            pgm_ctl_r <= sfr_wdata & FSPC_PGMCTL_MASK;
         end else if (sfr_addr == FSPC_FCTL_OFS) begin
            fctl_r <= sfr_wdata & FSPC_FCTL_MASK;
         end
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         limit_r <= FSPC_LIMIT_RST;
         limit_done_r <= 1'b0;
      end else if (sfr_wr && sfr_addr == FSPC_LIMIT_OFS && !limit_done_r) begin
         limit_r <= sfr_wdata;
         limit_done_r <= 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         sfr_rdata_r <= FSPC_ZERO_BYTE;
      end else if (sfr_rd) begin
         if (sfr_addr == FSPC_PGMCTL_OFS) begin
            sfr_rdata_r <= pgm_ctl_r;
         end else if (sfr_addr == FSPC_FCTL_OFS) begin
            sfr_rdata_r <= fctl_r;
         end else if (sfr_addr == FSPC_LIMIT_OFS) begin
            sfr_rdata_r <= limit_r;
         end else begin
            sfr_rdata_r <= FSPC_ZERO_BYTE;
         end
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         oneshot_en_r <= 1'b1;
         read_always_r <= 1'b0;
      end else begin
         oneshot_en_r <= fctl_r[FSPC_ONESHOT_BIT];
         read_always_r <= fctl_r[FSPC_RDALW_BIT];
      end
   end

   // ***********************************************************************
   // Software partition and enable checks
   // ***********************************************************************
   assign limit_addr = {limit_r, FSPC_ZERO_BYTE};
   assign upper_code = sw_pc >= limit_addr;
   assign below = sw_addr < limit_addr;
   assign in_lock_page = sw_addr[ADDR_W-1:FSPC_PAGE_SHIFT] == FSPC_LOCK_PAGE_BASE[ADDR_W-1:FSPC_PAGE_SHIFT];
   assign sw_er = pgm_ctl_r[FSPC_ER_EN_BIT];
   // Scratchpad accesses bypass the partition test; its map is separate
   assign sw_wr_ok = sw_wr && pgm_ctl_r[FSPC_WR_EN_BIT] && fctl_r[FSPC_FLSW_EN_BIT]
                     && !(upper_code && below && !pgm_ctl_r[FSPC_SCR_SEL_BIT])
                     && !(sw_er && in_lock_page && !pgm_ctl_r[FSPC_SCR_SEL_BIT]);
   assign is_lock_adr = (jt_addr == FSPC_WELOCK_ADDR) || (jt_addr == FSPC_RDLOCK_ADDR);

   fspc_lock_eval #(
      .ADDR_W(ADDR_W)
   ) u_lock (
      .mclk(mclk),
      .resetn(resetn),
      .rd_lock(rd_lock_r),
      .we_lock(we_lock_r),
      .addr(jt_addr),
      .scratch(1'b0),
      .rd_ok_r(rd_ok),
      .we_ok_r(we_ok)
   );

   // ***********************************************************************
   // Flash sequencer
   // ***********************************************************************
   // JTAG requests are held one cycle so the registered permission lines up
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         state_r <= FSPC_ST_LOAD;
         load_cnt_r <= 2'b00;
         flash_req_r <= 1'b0;
         flash_op_r <= FSPC_OP_NONE;
         flash_addr_r <= '0;
         flash_wdata_r <= FSPC_ZERO_BYTE;
         flash_scratch_r <= 1'b0;
         flash_rd_r <= 1'b0;
         jt_pend_r <= 1'b0;
         jt_req_r <= 3'b000;
         rd_src_r <= 1'b0;
         sw_rdata_r <= FSPC_ZERO_BYTE;
         sw_rvalid_r <= 1'b0;
         jt_rdata_r <= FSPC_ZERO_BYTE;
         jt_rvalid_r <= 1'b0;
         jt_refused_r <= 1'b0;
         rd_lock_r <= FSPC_ZERO_BYTE;
         we_lock_r <= FSPC_ZERO_BYTE;
         busy_r <= 1'b1;
      end else begin
         flash_req_r <= 1'b0;
         flash_rd_r <= 1'b0;
         sw_rvalid_r <= 1'b0;
         jt_rvalid_r <= 1'b0;
         jt_refused_r <= 1'b0;
         case (state_r)
            FSPC_ST_LOAD: begin
               // Reload both lock bytes so later checks see the array
               busy_r <= 1'b1;
               if (load_cnt_r == 2'b00 || load_cnt_r == 2'b10) begin
                  flash_rd_r <= 1'b1;
                  flash_scratch_r <= 1'b0;
                  flash_addr_r <= (load_cnt_r == 2'b00) ? FSPC_WELOCK_ADDR : FSPC_RDLOCK_ADDR;
                  load_cnt_r <= load_cnt_r + 2'b01;
               end else if (load_cnt_r == 2'b01) begin
                  we_lock_r <= flash_rdata;
                  load_cnt_r <= 2'b10;
               end else begin
                  rd_lock_r <= flash_rdata;
                  load_cnt_r <= 2'b00;
                  state_r <= FSPC_ST_IDLE;
                  busy_r <= 1'b0;
               end
            end
            FSPC_ST_IDLE: begin
               jt_pend_r <= (jt_rd || jt_wr || jt_erase) && !jt_pend_r;
               // Request kind is kept: the pulse is gone when the permission arrives
               jt_req_r <= {jt_erase, jt_wr, jt_rd};
               if (jt_pend_r) begin
                  flash_addr_r <= jt_addr;
                  flash_scratch_r <= 1'b0;
                  flash_wdata_r <= jt_wdata;
                  if (jt_req_r[2] && is_lock_adr) begin
                     flash_op_r <= FSPC_OP_MASS_ERASE;
                     flash_req_r <= 1'b1;
                     state_r <= FSPC_ST_BUSY;
                     busy_r <= 1'b1;
                  end else if (jt_req_r[2] && we_ok) begin
                     flash_op_r <= FSPC_OP_PAGE_ERASE;
                     flash_req_r <= 1'b1;
                     state_r <= FSPC_ST_BUSY;
                     busy_r <= 1'b1;
                  end else if (jt_req_r[1] && we_ok) begin
                     flash_op_r <= FSPC_OP_WRITE;
                     flash_req_r <= 1'b1;
                     state_r <= FSPC_ST_BUSY;
                     busy_r <= 1'b1;
                  end else if (jt_req_r[0] && rd_ok) begin
                     flash_rd_r <= 1'b1;
                     rd_src_r <= 1'b1;
                  end else if (jt_req_r[0]) begin
                     jt_rdata_r <= FSPC_UNDEF_BYTE;
                     jt_rvalid_r <= 1'b1;
                     jt_refused_r <= 1'b1;
                  end else begin
                     jt_refused_r <= 1'b1;
                  end
               end else if (rd_src_r) begin
                  rd_src_r <= 1'b0;
                  jt_rdata_r <= flash_rdata;
                  jt_rvalid_r <= 1'b1;
               end else if (sw_rd) begin
                  if (upper_code && below && !pgm_ctl_r[FSPC_SCR_SEL_BIT]) begin
                     sw_rdata_r <= FSPC_ZERO_BYTE;
                     sw_rvalid_r <= 1'b1;
                  end else begin
                     flash_rd_r <= 1'b1;
                     flash_addr_r <= sw_addr;
                     flash_scratch_r <= pgm_ctl_r[FSPC_SCR_SEL_BIT];
                     state_r <= FSPC_ST_BUSY;
                     flash_op_r <= FSPC_OP_NONE;
                  end
               end else if (sw_wr_ok) begin
                  flash_req_r <= 1'b1;
                  flash_addr_r <= sw_addr;
                  flash_wdata_r <= sw_wdata;
                  flash_scratch_r <= pgm_ctl_r[FSPC_SCR_SEL_BIT];
                  flash_op_r <= sw_er ? FSPC_OP_PAGE_ERASE : FSPC_OP_WRITE;
                  state_r <= FSPC_ST_BUSY;
                  busy_r <= 1'b1;
               end
            end
            FSPC_ST_BUSY: begin
               if (flash_op_r == FSPC_OP_NONE) begin
                  sw_rdata_r <= flash_rdata;
                  sw_rvalid_r <= 1'b1;
                  state_r <= FSPC_ST_IDLE;
               end else if (flash_done) begin
                  state_r <= FSPC_ST_LOAD;
                  flash_op_r <= FSPC_OP_NONE;
               end
            end
            default: begin
               state_r <= FSPC_ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         debug_ok_r <= 1'b0;
      end else begin
         debug_ok_r <= rd_lock_r[sw_pc[ADDR_W-1:FSPC_BLOCK_SHIFT]];
      end
   end

   // ***********************************************************************
   // Checks
   // ***********************************************************************
   limit_once_a: assert property (@(posedge mclk) disable iff (!resetn)
      limit_done_r |=> $stable(limit_r))
      else $error("access limit changed after first write");
   fctl_resv_a: assert property (@(posedge mclk) disable iff (!resetn)
      (fctl_r & ~FSPC_FCTL_MASK) == FSPC_ZERO_BYTE)
      else $error("reserved control bits set");
   sw_block_a: assert property (@(posedge mclk) disable iff (!resetn)
      (state_r == FSPC_ST_IDLE && !jt_pend_r && !rd_src_r && !sw_rd && sw_wr && !fctl_r[FSPC_FLSW_EN_BIT])
      |=> !flash_req_r)
      else $error("software write without enable");
   upper_zero_a: assert property (@(posedge mclk) disable iff (!resetn)
      (state_r == FSPC_ST_IDLE && !jt_pend_r && !rd_src_r && sw_rd && upper_code && below
       && !pgm_ctl_r[FSPC_SCR_SEL_BIT]) |=> sw_rvalid_r && sw_rdata_r == FSPC_ZERO_BYTE)
      else $error("upper partition read below limit not zero");
   lockpg_noer_a: assert property (@(posedge mclk) disable iff (!resetn)
      (flash_req_r && flash_op_r == FSPC_OP_PAGE_ERASE && !flash_scratch_r && !$past(jt_pend_r))
      |-> flash_addr_r[ADDR_W-1:FSPC_PAGE_SHIFT] != FSPC_LOCK_PAGE_BASE[ADDR_W-1:FSPC_PAGE_SHIFT])
      else $error("software erased lock page");
   mass_jtag_a: assert property (@(posedge mclk) disable iff (!resetn)
      (flash_req_r && flash_op_r == FSPC_OP_MASS_ERASE) |-> $past(jt_pend_r) && $past(jt_req_r[2]))
      else $error("mass erase not from debug port");
   jt_rdlock_a: assert property (@(posedge mclk) disable iff (!resetn)
      jt_refused_r && jt_rvalid_r |-> jt_rdata_r == FSPC_UNDEF_BYTE)
      else $error("locked read returned data");
   oneshot_rst_a: assert property (@(posedge mclk) disable iff (!resetn)
      $rose(limit_done_r) |-> oneshot_en_r == $past(fctl_r[FSPC_ONESHOT_BIT], 1))
      else $error("one-shot output out of step");
   mass_c: cover property (@(posedge mclk) disable iff (!resetn) flash_req_r && flash_op_r == FSPC_OP_MASS_ERASE);
   swwr_c: cover property (@(posedge mclk) disable iff (!resetn) flash_req_r && flash_op_r == FSPC_OP_WRITE);
   refuse_c: cover property (@(posedge mclk) disable iff (!resetn) jt_refused_r);
   zero_c: cover property (@(posedge mclk) disable iff (!resetn) sw_rvalid_r && upper_code);
endmodule : fspc_core

// *** dv/fspc_flash_model.sv ***
// Purpose: Behavioural flash array on the far side of the control core
// Assumes: One op per request pulse; read data shown while the read strobe stands
// Notes: Lock bytes preset by parameters; reserved area not modelled
`timescale 1ns/1ps
module fspc_flash_model
   import fspc_pkg::*;
#(
   parameter int DLY = 3,
   parameter logic [7:0] WE_LOCK = 8'hbf,
   parameter logic [7:0] RD_LOCK = 8'h7d
) (
   input wire logic mclk,
   input wire logic flash_req,
   input wire fspc_op_t flash_op,
   input wire logic [15:0] flash_addr,
   input wire logic [7:0] flash_wdata,
   input wire logic flash_scratch,
   input wire logic flash_rd,
   output logic flash_done,
   output logic [7:0] flash_rdata
);
   // ***********************************************************************
   // Array and timing
   // ***********************************************************************
   logic [7:0] mem [0:65535];
   logic [7:0] scr [0:127];
   logic [15:0] pa;
   logic [7:0] pd, raw;
   logic ps;
   fspc_op_t po;
   int cnt;
   initial begin
      foreach (mem[i]) mem[i] = 8'hff;
      foreach (scr[i]) scr[i] = 8'hff;
      mem[FSPC_WELOCK_ADDR] = WE_LOCK;
      mem[FSPC_RDLOCK_ADDR] = RD_LOCK;
      flash_done = 1'b0;
      cnt = 0;
   end
   // The core takes read data at the edge that ends its read strobe, so the array answers at once
   assign raw = flash_scratch ? scr[flash_addr[6:0]] : mem[flash_addr];
   // Idle port shows the inverse, so a late sample cannot pass by luck
   assign flash_rdata = flash_rd ? raw : ~raw;
   always @(posedge mclk) begin
      flash_done <= 1'b0;
      if (flash_req) begin
         cnt <= DLY;
         po <= flash_op;
         pa <= flash_addr;
         pd <= flash_wdata;
         ps <= flash_scratch;
      end else if (cnt == 1) begin
         cnt <= 0;
         flash_done <= 1'b1;
         case (po)
            FSPC_OP_WRITE: begin
               if (ps) scr[pa[6:0]] <= scr[pa[6:0]] & pd;
               else mem[pa] <= mem[pa] & pd;
            end
            FSPC_OP_PAGE_ERASE: for (int i = 0; i < 512; i++) begin
               if (ps && i < 128) scr[i] <= 8'hff;
               else if (!ps) mem[{pa[15:9], 9'h000} + 16'(i)] <= 8'hff;
            end
            FSPC_OP_MASS_ERASE: foreach (mem[i]) mem[i] <= 8'hff;
            default: ;
         endcase
      end else if (cnt > 1) cnt <= cnt - 1;
   end
endmodule : fspc_flash_model

// *** dv/test_fspc_core.sv ***
// Purpose: Self-checking bench for the flash security and program store control
// Assumes: Flash model answers after a short fixed delay
// Notes: Drivers queue expected results; one monitor compares them
`timescale 1ns/1ps
module test_fspc_core
   import fspc_pkg::*;
;
   // ***********************************************************************
   // Signals and checking
   // ***********************************************************************
   `define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin fail_count++; \
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp); end end
   logic mclk = 0, resetn = 0, sfr_wr = 0, sfr_rd = 0, sw_wr = 0, sw_rd = 0, jt_rd = 0, jt_wr = 0, jt_erase = 0;
   logic [7:0] sfr_addr = '0, sfr_wdata = '0, sw_wdata = '0, jt_wdata = '0, d1, d2, d3;
   logic [15:0] sw_addr = '0, sw_pc = '0, jt_addr = '0, a;
   logic [7:0] sfr_rdata, sw_rdata, jt_rdata, flash_wdata, flash_rdata;
   logic sw_rvalid, jt_rvalid, jt_refused, debug_ok, flash_req, flash_scratch, flash_rd, flash_done;
   logic oneshot_en, read_always, busy, sfr_pend = 0;
   logic [15:0] flash_addr;
   fspc_op_t flash_op;
   int fail_count = 0, tests_run = 0;
   logic [31:0] seed = 32'h148a;
   logic [7:0] qs[$], qw[$];
   logic [8:0] qj[$], e;
   always #50 mclk = ~mclk;
   fspc_core fspc_core_i (.mclk(mclk), .resetn(resetn), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_addr(sfr_addr),
      .sfr_wdata(sfr_wdata), .sfr_rdata_r(sfr_rdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_addr(sw_addr),
      .sw_wdata(sw_wdata), .sw_pc(sw_pc), .sw_rdata_r(sw_rdata), .sw_rvalid_r(sw_rvalid), .jt_rd(jt_rd),
      .jt_wr(jt_wr), .jt_erase(jt_erase), .jt_addr(jt_addr), .jt_wdata(jt_wdata), .jt_rdata_r(jt_rdata),
      .jt_rvalid_r(jt_rvalid), .jt_refused_r(jt_refused), .debug_ok_r(debug_ok), .flash_req_r(flash_req),
      .flash_op_r(flash_op), .flash_addr_r(flash_addr), .flash_wdata_r(flash_wdata),
      .flash_scratch_r(flash_scratch), .flash_rd_r(flash_rd), .flash_done(flash_done),
      .flash_rdata(flash_rdata), .oneshot_en_r(oneshot_en), .read_always_r(read_always), .busy_r(busy));
   fspc_flash_model fspc_flash_model_i (.mclk(mclk), .flash_req(flash_req), .flash_op(flash_op),
      .flash_addr(flash_addr), .flash_wdata(flash_wdata), .flash_scratch(flash_scratch), .flash_rd(flash_rd),
      .flash_done(flash_done), .flash_rdata(flash_rdata));
   always @(posedge mclk) sfr_pend <= sfr_rd;
   always @(negedge mclk) begin
      if (sfr_pend) begin
         e = qs.size() ? qs.pop_front() : 8'bx;
         `CHK(sfr_rdata, e[7:0])
      end
      if (sw_rvalid === 1'b1) begin
         e = qw.size() ? qw.pop_front() : 8'bx;
         `CHK(sw_rdata, e[7:0])
      end
      if (jt_rvalid === 1'b1 || jt_refused === 1'b1) begin
         e = qj.size() ? qj.pop_front() : 9'bx;
         `CHK({jt_refused, jt_rvalid ? jt_rdata : 8'h00}, e)
      end
   end
   // ***********************************************************************
   // Drivers
   // ***********************************************************************
   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction : rnd
   task automatic tick(int n = 1);
      repeat (n) @(negedge mclk);
   endtask : tick
   task automatic idle();
      int k;
      tick(4);
      for (k = 0; k < 400 && busy !== 1'b0; k++) tick();
      if (k == 400) `CHK(busy, 1'b0)
   endtask : idle
   task automatic sfr(input logic w, input logic [7:0] ad, d, exp);
      sfr_wr = w;
      sfr_rd = !w;
      sfr_addr = ad;
      sfr_wdata = d;
      if (!w) qs.push_back(exp);
      tick();
      sfr_wr = 0;
      sfr_rd = 0;
      tick();
   endtask : sfr
   task automatic sw(input logic w, input logic [15:0] ad, pc, input logic [7:0] d);
      sw_wr = w;
      sw_rd = !w;
      sw_addr = ad;
      sw_pc = pc;
      sw_wdata = d;
      if (!w) qw.push_back(d);
      tick();
      sw_wr = 0;
      sw_rd = 0;
      idle();
   endtask : sw
   // Address and data stay put after the pulse, covering the two-cycle hold
   task automatic jt(input int k, input logic [15:0] ad, input logic [7:0] d, input logic [8:0] exp);
      jt_rd = (k == 0);
      jt_wr = (k == 1);
      jt_erase = (k == 2);
      jt_addr = ad;
      jt_wdata = d;
      if (exp[8] || k == 0) qj.push_back(exp);
      tick();
      jt_rd = 0;
      jt_wr = 0;
      jt_erase = 0;
      idle();
   endtask : jt
   task automatic stop_test();
      if (fail_count == 0 && tests_run > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : stop_test
   initial begin
      #(100 * 5000);
      fail_count++;
      stop_test();
   end
   // ***********************************************************************
   // Scenarios
   // ***********************************************************************
   initial begin
      tick(8);
      resetn = 1;
      idle();
      `CHK({oneshot_en, read_always}, 2'b10)
      sfr(0, FSPC_PGMCTL_OFS, 0, 8'h00);
      sfr(0, FSPC_LIMIT_OFS, 0, 8'h00);
      sfr(0, FSPC_FCTL_OFS, 0, 8'h80);
      sfr(0, 8'h12, 0, 8'h00);
      sfr(1, FSPC_FCTL_OFS, 8'hc1, 0);
      sfr(0, FSPC_FCTL_OFS, 0, 8'hc1);
      `CHK(read_always, 1'b1)
      sfr(1, FSPC_FCTL_OFS, 8'h01, 0);
      `CHK({oneshot_en, read_always}, 2'b00)
      sfr(1, FSPC_LIMIT_OFS, 8'h40, 0);
      sfr(1, FSPC_LIMIT_OFS, 8'h80, 0);
      sfr(0, FSPC_LIMIT_OFS, 0, 8'h40);
      d1 = rnd();
      d2 = rnd();
      d3 = rnd();
      a = {8'h41, rnd()};
      jt(1, 16'h0100, d1, 0);
      jt(0, 16'h0100, 0, {1'b0, d1});
      jt(0, 16'h2100, 0, 9'h100);
      jt(1, 16'hc000, d1, 9'h100);
      jt(0, 16'hfdfe, 0, 9'h0bf);
      sw_pc = 16'h2000;
      tick(2);
      `CHK(debug_ok, 1'b0)
      sw(0, 16'h0100, 16'h8000, 8'h00);
      `CHK(debug_ok, 1'b1)
      sw(0, 16'h0100, 16'h0000, d1);
      sw(0, a, 16'h8000, 8'hff);
      sw(1, a, 16'h0, d2);
      sfr(1, FSPC_PGMCTL_OFS, 8'h01, 0);
      sfr(1, FSPC_FCTL_OFS, 8'h00, 0);
      sw(1, a, 16'h0, d2);
      sw(0, a, 16'h0, 8'hff);
      sfr(1, FSPC_FCTL_OFS, 8'h01, 0);
      sw(1, 16'h0100, 16'h8000, 8'h00);
      sw(0, 16'h0100, 16'h0, d1);
      sw(1, a, 16'h0, d2);
      sw(0, a, 16'h0, d2);
      sfr(1, FSPC_PGMCTL_OFS, 8'h03, 0);
      sw(1, a, 16'h0, d3);
      sw(0, a, 16'h0, 8'hff);
      sw(1, 16'hfc10, 16'h0, 0);
      jt(0, 16'hfdfe, 0, 9'h0bf);
      sfr(1, FSPC_PGMCTL_OFS, 8'h01, 0);
      sw(1, 16'hfdfe, 16'h0, 8'h3f);
      jt(0, 16'hfdfe, 0, 9'h03f);
      sfr(1, FSPC_PGMCTL_OFS, 8'h05, 0);
      sw(1, 16'h0010, 16'h0, d3);
      sw(0, 16'h0010, 16'h0, d3);
      sfr(1, FSPC_PGMCTL_OFS, 8'h00, 0);
      sw(0, 16'h0010, 16'h0, 8'hff);
      jt(2, 16'hfc10, 0, 9'h100);
      jt(2, 16'hfdfe, 0, 0);
      jt(0, 16'h2100, 0, 9'h0ff);
      jt(0, 16'hfdff, 0, 9'h0ff);
      // A second reset must reopen the access limit for one more write
      resetn = 0;
      tick(2);
      `CHK({oneshot_en, read_always, busy}, 3'b101)
      resetn = 1;
      idle();
      sfr(0, FSPC_LIMIT_OFS, 0, 8'h00);
      sfr(1, FSPC_LIMIT_OFS, 8'h20, 0);
      sfr(0, FSPC_LIMIT_OFS, 0, 8'h20);
      jt(0, 16'hfdfe, 0, 9'h0ff);
      `CHK(qs.size() + qw.size() + qj.size(), 0)
      stop_test();
   end
endmodule : test_fspc_core
